// ---- design/shc_cfg.svh ----
// Purpose: Constants for the hidden-clock SRAM host controller.
// Assumes: 25 MHz mclk, 40 ns period.
// Notes: Times in ns; cycle counts derived from them.
`ifndef SHC_CFG_SVH
`define SHC_CFG_SVH
`define SHC_CLK_NS 40
`define SHC_ADDR_W 21
`define SHC_DATA_W 8
`define SHC_ACCESS_NS 150
`define SHC_ACCESS_CYC ((`SHC_ACCESS_NS + `SHC_CLK_NS - 1) / `SHC_CLK_NS)
`define SHC_WP_NS 100
`define SHC_WP_CYC ((`SHC_WP_NS + `SHC_CLK_NS - 1) / `SHC_CLK_NS)
`define SHC_WREC_NS 20
`define SHC_WREC_CYC ((`SHC_WREC_NS + `SHC_CLK_NS - 1) / `SHC_CLK_NS)
`define SHC_ODW_NS 70
`define SHC_ODW_CYC ((`SHC_ODW_NS + `SHC_CLK_NS - 1) / `SHC_CLK_NS)
`define SHC_UNLOCK_LIMIT 21'h07ffff
`define SHC_PAT_BITS 64
`define SHC_XFER_BITS 64
`define SHC_REG_BITS 8
`define SHC_DAY_REG 4
`define SHC_OSC_STOP_BIT 5
`define SHC_HOUR_REG 3
`define SHC_HOUR_12H_BIT 7
`define SHC_HOUR_PM_BIT 5
`endif

// ---- design/shc_cycle.sv ----
// Purpose: Runs one timed read or write cycle on the memory pins.
// Assumes: Memory inputs are synchronised by the caller's clock domain.
// Notes: One cycle at a time; done pulses for one clock.
`timescale 1ns/10ps
`default_nettype none
`include "shc_cfg.svh"
module shc_cycle (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Request side.
  input wire logic start,
  input wire shc_pkg::shc_op_t op,
  input wire logic [`SHC_ADDR_W-1:0] addr,
  input wire logic [`SHC_DATA_W-1:0] wdata,
  output logic busy,
  output logic done,
  output logic [`SHC_DATA_W-1:0] rdata,
  // Memory side.
  output shc_pkg::shc_pins_t pins,
  input wire logic [`SHC_DATA_W-1:0] dq_in_sync
);
  import shc_pkg::*;
  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_ACT = 2'b01,
    CY_REC = 2'b10
  } shc_cy_t;
  localparam int ACC_CYC = `SHC_ACCESS_CYC + 2;  // Two extra for the input synchroniser.
  shc_cy_t state_ff;  // Cycle phase.
  logic [3:0] cnt_ff;  // Phase timer.
  shc_op_t op_ff;  // Latched operation.
  // Phase sequencer; recovery with all strobes high follows every cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= CY_IDLE;
      cnt_ff <= 4'h0;
      op_ff <= SHC_OP_IDLE;
      pins <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_out: '0, dq_oe: 1'b0};
      rdata <= '0;
    end else begin
      unique case (state_ff)
        CY_IDLE: begin
          if (start && op != SHC_OP_IDLE) begin
            op_ff <= op;
            // Address settles with strobes and stays for the whole cycle.
            pins.addr <= addr;
            pins.ce_n <= 1'b0;
            // Output enable stays high on writes so nobody fights the bus.
            pins.oe_n <= (op == SHC_OP_WRITE);
            pins.we_n <= (op != SHC_OP_WRITE);
            pins.dq_out <= wdata;
            pins.dq_oe <= (op == SHC_OP_WRITE);
            cnt_ff <= (op == SHC_OP_WRITE) ? 4'(`SHC_WP_CYC) : 4'(ACC_CYC);
            state_ff <= CY_ACT;
          end
        end
        CY_ACT: begin
          if (cnt_ff == 4'h1) begin
            if (op_ff == SHC_OP_READ) begin
              rdata <= dq_in_sync;
            end
            pins.ce_n <= 1'b1;
            pins.oe_n <= 1'b1;
            pins.we_n <= 1'b1;
            cnt_ff <= 4'(`SHC_WREC_CYC);
            state_ff <= CY_REC;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        CY_REC: begin
          // Hold strobes high before the next cycle; drop data drive.
          pins.dq_oe <= 1'b0;
          if (cnt_ff == 4'h1) begin
            state_ff <= CY_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        default: state_ff <= CY_IDLE;
      endcase
    end
  end
  assign busy = (state_ff != CY_IDLE);
  assign done = (state_ff == CY_REC) && (cnt_ff == 4'h1);
  // Write enable stays high through the recovery clock and the idle step after it.
  // Two samples cover the single recovery clock with a clock to spare.
  a_write_recovery: assert property (@(posedge mclk) disable iff (srst)
    $rose(pins.we_n) |-> pins.we_n [*2])
    else $error("write enable recovery too short");
  // Output enable never falls while a write strobe is low.
  a_no_contention: assert property (@(posedge mclk) disable iff (srst)
    !pins.we_n |-> pins.oe_n)
    else $error("output enable low during write");
  // The address does not move while a write strobe stays low.
  a_addr_stable: assert property (@(posedge mclk) disable iff (srst)
    (!pins.we_n && !$past(pins.we_n)) |-> $stable(pins.addr))
    else $error("address moved during write");
endmodule : shc_cycle
`default_nettype wire

// ---- design/shc_host.sv ----
// Purpose: Host controller that reads and sets the clock hidden behind a byte-wide NV SRAM.
// Assumes: One memory on dedicated pins; power-fail flag comes in as a pin.
// Notes: Runs read-reset, 64 pattern writes, then 64 serial transfer cycles.
// Notes on behaviour
// - Host holds address through each write.
// - Host keeps WE high for recovery time.
// - Host keeps OE high while writing.
// - Sixty-four pattern writes on bit 0 unlock.
// - Unlock starts with a read cycle.
// - Unlock writes go below 80000h.
// - Unlock writes land on one scratch byte.
// - Eight 8-bit registers, whole bytes only.
`timescale 1ns/10ps
`default_nettype none
`include "shc_cfg.svh"
module shc_host #(
  parameter logic [63:0] UNLOCK_PATTERN = 64'h5ca3_3ac5_5ca3_3ac5,  // Plain default; set per part.
  parameter logic [20:0] SCRATCH_ADDR = 21'h000000,  // Scratch byte for unlock writes.
  parameter int PAT_BITS = `SHC_PAT_BITS
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // User command side.
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [63:0] cmd_wdata,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [63:0] rd_data,
  output logic pf_abort,
  // Memory pins.
  output logic [`SHC_ADDR_W-1:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic [`SHC_DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [`SHC_DATA_W-1:0] dq_in,
  input wire logic power_fail_n
);
  import shc_pkg::*;
  // Elaboration refuses settings that the sequencer cannot serve.
  if (PAT_BITS != 64) begin : g_bad_pat_len
    $error("pattern length must be 64");
  end
  // A scratch byte above the unlock region would never open the clock.
  if (SCRATCH_ADDR > `SHC_UNLOCK_LIMIT) begin : g_bad_scratch
    $error("scratch byte must lie below 80000h");
  end
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RESYNC = 3'b001,
    ST_PATTERN = 3'b010,
    ST_XFER = 3'b011,
    ST_WAIT = 3'b100
  } shc_st_t;
  shc_st_t state_ff;  // Sequence phase.
  shc_st_t after_ff;  // Phase that launched the running cycle.
  logic [6:0] idx_ff;  // Bit index within pattern or transfer.
  logic write_ff;  // Current command is a clock update.
  logic [63:0] shift_ff;  // Transfer shift register, register 0 bit 0 first.
  logic [63:0] rd_ff;  // Bits gathered on reads.
  logic rd_valid_ff;  // One-cycle read result strobe.
  logic abort_ff;  // One-cycle power-fail abort strobe.
  logic [`SHC_DATA_W-1:0] dq_s1_ff;  // Synchroniser first stage.
  logic [`SHC_DATA_W-1:0] dq_s2_ff;  // Synchroniser second stage.
  logic pf_s1_ff;  // Power-fail first stage.
  logic pf_s2_ff;  // Power-fail second stage.
  logic cy_start;  // Launch one bus cycle.
  shc_op_t cy_op;  // Kind of that cycle.
  logic [`SHC_ADDR_W-1:0] cy_addr;  // Its address.
  logic [`SHC_DATA_W-1:0] cy_wdata;  // Its write data.
  logic cy_busy;  // Cycle in flight.
  logic cy_done;  // Cycle finished.
  logic [`SHC_DATA_W-1:0] cy_rdata;  // Sampled read byte.
  shc_pins_t pins;  // Pin bundle from the cycle engine.
  // Pin inputs come from another device's timing, so two stages each.
  always_ff @(posedge mclk) begin
    dq_s1_ff <= dq_in;
    dq_s2_ff <= dq_s1_ff;
    pf_s1_ff <= power_fail_n;
    pf_s2_ff <= pf_s1_ff;
  end
  // The cycle engine owns pin timing so this file only decides what to run.
  shc_cycle u_cycle (
    .mclk(mclk),
    .srst(srst),
    .start(cy_start),
    .op(cy_op),
    .addr(cy_addr),
    .wdata(cy_wdata),
    .busy(cy_busy),
    .done(cy_done),
    .rdata(cy_rdata),
    .pins(pins),
    .dq_in_sync(dq_s2_ff)
  );
  // Read sets WE high and CE low; writes drop both, so write spans both lows.
  assign mem_addr = pins.addr;
  assign mem_ce_n = pins.ce_n;
  assign mem_oe_n = pins.oe_n;
  assign mem_we_n = pins.we_n;
  assign dq_out = pins.dq_out;
  assign dq_oe = pins.dq_oe;
  // A new cycle starts only in a phase that needs one and while power is good.
  always_comb begin
    cy_start = 1'b0;
    cy_op = SHC_OP_IDLE;
    cy_addr = SCRATCH_ADDR;
    cy_wdata = '0;
    if (!cy_busy && pf_s2_ff) begin
      unique case (state_ff)
        ST_RESYNC: begin
          cy_start = 1'b1;
          cy_op = SHC_OP_READ;
        end
        ST_PATTERN: begin
          cy_start = 1'b1;
          cy_op = SHC_OP_WRITE;
          cy_wdata = {7'h00, UNLOCK_PATTERN[idx_ff[5:0]]};
        end
        ST_XFER: begin
          cy_start = 1'b1;
          cy_op = write_ff ? SHC_OP_WRITE : SHC_OP_READ;
          cy_wdata = {7'h00, shift_ff[0]};
        end
        ST_IDLE, ST_WAIT: begin
          cy_start = 1'b0;
        end
      endcase
    end
  end
  // Sequence control: read to reset pointer, 64 pattern bits, 64 transfer bits.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      after_ff <= ST_IDLE;
      idx_ff <= 7'h00;
      write_ff <= 1'b0;
      shift_ff <= '0;
      rd_ff <= '0;
      rd_valid_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      rd_valid_ff <= 1'b0;
      abort_ff <= 1'b0;
      if (!pf_s2_ff && state_ff != ST_IDLE && !cy_busy) begin
        // Power lost mid-sequence: the device dropped state, so do we.
        state_ff <= ST_IDLE;
        abort_ff <= 1'b1;
      end else begin
        unique case (state_ff)
          ST_IDLE: begin
            if (cmd_valid && pf_s2_ff) begin
              write_ff <= cmd_write;
              shift_ff <= cmd_wdata;
              state_ff <= ST_RESYNC;
            end
          end
          ST_RESYNC, ST_PATTERN, ST_XFER: begin
            if (cy_start) begin
              after_ff <= state_ff;
              state_ff <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (cy_done) begin
              unique case (after_ff)
                ST_RESYNC: begin
                  idx_ff <= 7'h00;
                  state_ff <= ST_PATTERN;
                end
                ST_PATTERN: begin
                  if (idx_ff == 7'(PAT_BITS - 1)) begin
                    idx_ff <= 7'h00;
                    state_ff <= ST_XFER;
                  end else begin
                    idx_ff <= idx_ff + 7'h01;
                    state_ff <= ST_PATTERN;
                  end
                end
                default: begin
                  shift_ff <= {1'b0, shift_ff[63:1]};
                  rd_ff <= {cy_rdata[0], rd_ff[63:1]};
                  if (idx_ff == 7'(`SHC_XFER_BITS - 1)) begin
                    idx_ff <= 7'h00;
                    rd_valid_ff <= ~write_ff;
                    state_ff <= ST_IDLE;
                  end else begin
                    idx_ff <= idx_ff + 7'h01;
                    state_ff <= ST_XFER;
                  end
                end
              endcase
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end
  // Result word goes out from flip-flops once all 64 bits are in.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_data <= '0;
    end else if (state_ff == ST_WAIT && cy_done && after_ff == ST_XFER
                 && idx_ff == 7'(`SHC_XFER_BITS - 1)) begin
      rd_data <= {cy_rdata[0], rd_ff[63:1]};
    end
  end
  assign cmd_ready = (state_ff == ST_IDLE) && pf_s2_ff;
  assign rd_valid = rd_valid_ff;
  assign pf_abort = abort_ff;
  // Every strobe the host lowers stays inside the unlock region.
  a_unlock_low: assert property (@(posedge mclk) disable iff (srst)
    !mem_ce_n |-> mem_addr <= `SHC_UNLOCK_LIMIT)
    else $error("access outside scratch region");
  // Checked on the pins, so a broken data path cannot hide behind the request.
  a_pattern_bit: assert property (@(posedge mclk) disable iff (srst)
    (state_ff == ST_WAIT && after_ff == ST_PATTERN && !mem_we_n)
      |-> dq_out[0] == UNLOCK_PATTERN[idx_ff[5:0]])
    else $error("pattern bit out of order");
  // A new sequence opens with a read cycle.
  a_start_read: assert property (@(posedge mclk) disable iff (srst)
    (state_ff == ST_IDLE ##1 state_ff == ST_RESYNC) |-> ##[0:3] (cy_start && cy_op == SHC_OP_READ))
    else $error("sequence did not open with a read");
  // With power reported low no new strobe may fall on the pins.
  a_power_gate: assert property (@(posedge mclk) disable iff (srst)
    (!pf_s2_ff && mem_ce_n) |=> mem_ce_n)
    else $error("cycle launched under power fail");
  // The last transfer bit hands the bus back to plain memory use.
  a_xfer_end: assert property (@(posedge mclk) disable iff (srst)
    (state_ff == ST_WAIT && after_ff == ST_XFER && cy_done && idx_ff == 7'd63)
      |=> state_ff == ST_IDLE)
    else $error("transfer did not end after 64 bits");
endmodule : shc_host
`default_nettype wire

// ---- design/shc_pkg.sv ----
// Purpose: Types for the hidden-clock SRAM host controller.
// Assumes: Constants come from shc_cfg.svh.
// Notes: Pins toward the memory travel as one struct; read data comes back as a plain byte.
`include "shc_cfg.svh"
package shc_pkg;
  // Bus cycle kinds the sequencer can run.
  typedef enum logic [1:0] {
    SHC_OP_READ = 2'b00,
    SHC_OP_WRITE = 2'b01,
    SHC_OP_IDLE = 2'b10
  } shc_op_t;
  // Pins driven toward the memory.
  typedef struct packed {
    logic [`SHC_ADDR_W-1:0] addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [`SHC_DATA_W-1:0] dq_out;
    logic dq_oe;
  } shc_pins_t;
endpackage : shc_pkg

// ---- tb/shc_host_tb_top.sv ----
// Purpose: Self-checking bench for the hidden-clock host controller.
// Assumes: Model pattern equals the controller's pattern.
// Notes: Each clock command takes roughly a thousand clocks.
`timescale 1ns/10ps
`default_nettype none
`include "shc_cfg.svh"
module shc_host_tb_top;
  localparam logic [63:0] PAT = 64'h9e37_1c4d_a5b2_0f68;
  localparam logic [63:0] INIT = 64'h1234_5678_9abc_def0;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [63:0] cmd_wdata = 64'h0;
  logic power_fail_n = 1'b1;
  logic cmd_ready, rd_valid, pf_abort, mem_ce_n, mem_oe_n, mem_we_n, dq_oe;
  logic [63:0] rd_data, img;
  logic [`SHC_ADDR_W-1:0] mem_addr;
  logic [7:0] dq_out, dq_in;
  int viol, sessions;
  int exp_sess = 0;
  int err_count = 0;
  int n_tests = 0;
  always #20 mclk = ~mclk;
  shc_host #(.UNLOCK_PATTERN(PAT)) DUT (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .pf_abort(pf_abort), .mem_addr(mem_addr),
    .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in), .power_fail_n(power_fail_n));
  shc_nvram_model #(.PATTERN(PAT), .INIT_IMG(INIT)) u_mem (.mem_addr(mem_addr),
    .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n), .dq_out(dq_out), .dq_oe(dq_oe),
    .power_ok(power_fail_n), .dq_in(dq_in), .viol(viol), .sessions(sessions), .img(img));
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds a request from a falling edge until the edge that takes it.
  task automatic issue(input logic wr, input logic [63:0] d);
    int k;
    k = 0;
    @(negedge mclk);
    while (cmd_ready !== 1'b1 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask : issue
  // Runs a whole command and waits, bounded, for its end.
  task automatic run_cmd(input logic wr, input logic [63:0] d);
    int k;
    k = 0;
    issue(wr, d);
    while ((wr ? cmd_ready : rd_valid) !== 1'b1 && k < 4000) begin
      @(negedge mclk);
      k++;
    end
    chk(64'(k < 4000), 64'h1);
    exp_sess++;
    chk(64'(sessions), 64'(exp_sess));
  endtask : run_cmd
  task automatic t_read(input logic [63:0] exp);
    run_cmd(1'b0, 64'h0);
    chk(rd_data, exp);
    $display("test read done");
  endtask : t_read
  task automatic t_write_read(input logic [63:0] d);
    run_cmd(1'b1, d);
    chk(img, d);
    chk(64'(u_mem.osc_stop), 64'(d[8 * `SHC_DAY_REG + `SHC_OSC_STOP_BIT]));
    chk(64'(u_mem.hour_12h), 64'(d[8 * `SHC_HOUR_REG + `SHC_HOUR_12H_BIT]));
    run_cmd(1'b0, 64'h0);
    chk(rd_data, d);
    $display("test write then read done");
  endtask : t_write_read
  // Supply drops during the unlock writes; the image must survive.
  task automatic t_power(input logic [63:0] d);
    int k;
    k = 0;
    issue(1'b1, ~d);
    repeat (200) @(negedge mclk);
    power_fail_n = 1'b0;
    while (pf_abort !== 1'b1 && k < 40) begin
      @(negedge mclk);
      k++;
    end
    chk(64'(k < 40), 64'h1);
    chk(64'(cmd_ready), 64'h0);
    repeat (10) @(negedge mclk);
    power_fail_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk(img, d);
    t_read(d);
    $display("test power fail done");
  endtask : t_power
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(negedge mclk);
    chk(64'({mem_ce_n, mem_oe_n, mem_we_n, dq_oe, mem_addr}), 64'({4'b1110, 21'h0}));
    srst = 1'b0;
    $display("test reset done");
    t_read(INIT);
    t_write_read(64'hffff_ffff_ffff_ffff);
    t_write_read(64'h0123_4567_89ab_cdef);
    t_power(64'h0123_4567_89ab_cdef);
    chk(64'(viol), 64'h0);
    complete_run();
  end
  // Cuts a hang short well past the expected five thousand clocks.
  initial begin
    #(40 * 30000);
    err_count++;
    complete_run();
  end
endmodule : shc_host_tb_top
`default_nettype wire

// ---- tb/shc_nvram_model.sv ----
// Purpose: Behavioural NV SRAM with a serial clock hidden behind its bus.
// Assumes: Host pins change only on its own clock edges.
// Notes: One access delay covers address and strobes, the slower case.
`timescale 1ns/10ps
`default_nettype none
`include "shc_cfg.svh"
module shc_nvram_model #(
  parameter logic [63:0] PATTERN = 64'h0,
  parameter logic [63:0] INIT_IMG = 64'h0,
  parameter int ACC_NS = 150,
  parameter int WR_NS = 20
) (
  // Host pins.
  input wire logic [`SHC_ADDR_W-1:0] mem_addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic power_ok,
  // Data back and status.
  output logic [7:0] dq_in,
  output int viol,
  output int sessions,
  output logic [63:0] img
);
  logic [7:0] mem [0:2**21-1];
  logic [22:0] sel_d;  // Pins seen one access time late.
  logic [7:0] rd_val, last_q, wd;
  logic [20:0] wa;
  logic rd_on, wr_on, was_rd, was_wr, open_q, live_q, drv;
  int ptr, xidx;
  realtime t_we;
  logic osc_stop, hour_12h;
  // Oscillator stop and 12-hour select live in the image; the host never decodes them.
  assign osc_stop = img[8 * `SHC_DAY_REG + `SHC_OSC_STOP_BIT];
  assign hour_12h = img[8 * `SHC_HOUR_REG + `SHC_HOUR_12H_BIT];
  initial begin
    {viol, sessions, ptr, xidx} = '0;
    {was_rd, was_wr, open_q, live_q} = '0;
    img = INIT_IMG;
    last_q = 8'h00;
    t_we = 0;
  end
  // Data shows only once pins rested; otherwise the bus floats to junk.
  assign #(ACC_NS) sel_d = {mem_addr, ce_n, oe_n};
  always @* begin
    rd_val = open_q ? {7'h2a, img[xidx]} : mem[mem_addr];
    drv = power_ok && !ce_n && !oe_n && we_n && sel_d === {mem_addr, ce_n, oe_n};
    dq_in = drv ? rd_val : ~last_q;
    if (drv) begin
      last_q = rd_val;
    end
  end
  // One transfer bit; the last one closes the clock window.
  task automatic step(input logic wr, input logic b);
    if (wr) begin
      img[xidx] = b;
    end
    xidx++;
    if (xidx == 64) begin
      {open_q, live_q} = 2'b00;
      ptr = 0;
      sessions++;
    end
  endtask : step
  // Cycle tracking; deselected cycles never reach this state.
  always @(mem_addr, dq_out, dq_oe, ce_n, oe_n, we_n, power_ok) begin
    // Let all pins of one host edge settle, so a write start never looks like a read.
    #1;
    rd_on = power_ok && !ce_n && we_n;
    wr_on = power_ok && !ce_n && !we_n;
    if (!power_ok) begin
      {open_q, live_q} = 2'b00;
      ptr = 0;
    end
    if ((wr_on && !was_wr) || (rd_on && !was_rd)) begin
      if ($realtime - t_we < WR_NS) viol++;
      wa = mem_addr;
    end
    if (wr_on) begin
      if (mem_addr !== wa || oe_n !== 1'b1 || dq_oe !== 1'b1) viol++;
      wd = dq_out;
    end
    if (was_wr && !we_n === 1'b0) t_we = $realtime;
    if (was_wr && !wr_on && power_ok) begin
      if (open_q) begin
        step(1'b1, wd[0]);
      end else begin
        mem[wa] = wd;
        if (wa > 21'h07ffff) viol++;
        if (live_q && wd[0] === PATTERN[ptr]) ptr++;
        else live_q = 1'b0;
        if (live_q && ptr == 64) begin
          open_q = 1'b1;
          xidx = 0;
        end
      end
    end
    if (was_rd && !rd_on && power_ok) begin
      if (open_q) begin
        step(1'b0, 1'b0);
      end else begin
        ptr = 0;
        live_q = 1'b1;
      end
    end
    was_wr = wr_on;
    was_rd = rd_on;
  end
endmodule : shc_nvram_model
`default_nettype wire
